/* File: inc/ppp_defines.svh */
// Constants for the parallel peripheral port: register offsets, fields, timing.
// Assumes an APB slave with 32-bit data and byte addressing.
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH
`define OFF_CTRL 8'ha0
`define OFF_STAT 8'ha4
`define OFF_MASK 8'ha8
`define OFF_IRQ 8'hac
`define OFF_LATCH 8'hb0
`define OFF_GPO 8'hb4
`define ADDR_MSB 7
// Control register fields
`define C_ENABLE 0
`define C_MODE_LO 1
`define C_MODE_HI 3
`define C_FULLWORD 4
`define C_CMD_POL 5
`define C_ABC 6
`define C_REVERSE_DRIVE_ENABLE 7
// Mode field codes
`define MODE_COMPAT 3'h1
`define MODE_NIBBLE 3'h2
`define MODE_BYTE 3'h3
`define MODE_ECP_FWD 3'h4
`define MODE_ECP_REV 3'h5
// Timing: latch pulse widths in ns, cycle counts at 10 ns
`define CLK_NS 10
`define COMPAT_PULSE_NS 50
`define ECP_PULSE_NS 20
`define COMPAT_PULSE_CYC ((`COMPAT_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define ECP_PULSE_CYC ((`ECP_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define RESET_ZERO 32'h0000_0000
`define BYTES_PER_WORD 2'h3
`endif

/* File: inc/ppp_pkg.sv */
// Types shared by the parallel peripheral port.
// Assumes ppp_defines.svh supplies the numeric constants.
package ppp_pkg;
  // Host-side inputs, already inverted at the pins
  typedef struct packed {
    logic strobe;
    logic autofeed;
    logic active;
    logic init;
    logic ecp_cmd;
  } host_in_s;
  // Software-driven status lines
  typedef struct packed {
    logic fault;
    logic paper_error;
    logic select;
  } soft_status_s;
endpackage

/* File: verilog/parallel_peripheral_port.sv */
// Peripheral-side parallel port with APB registers and external latch decode.
// Assumes pins are inverted by outside buffers and inputs are synchronous to clk.
// Assumes an APB master with one setup cycle; the latch data bus lies outside.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "ppp_defines.svh"
module parallel_peripheral_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ppp_pkg::host_in_s host_in,
  input wire logic gpio_pin6_out,
  input wire logic gpio_pin8_out,
  input wire logic transfer_ack,
  output logic peripheral_ack_out,
  output logic peripheral_busy_out,
  output logic latch_read_enable,
  output logic latch_write_enable,
  output logic forward_latch_pulse,
  output logic reverse_drive_enable,
  output ppp_pkg::soft_status_s status_out,
  output logic transfer_request,
  output logic control_irq,
  output logic data_irq
);

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_PULSE,
    HS_WAIT,
    HS_RELEASE
  } hs_e;

  hs_e hs_state;
  logic [31:0] ctrl;
  logic [7:0] rise_mask;
  logic [7:0] fall_mask;
  logic data_mask;
  logic [7:0] edge_stat;
  logic data_stat;
  logic [1:0] byte_count;
  logic [2:0] pulse_cnt;
  ppp_pkg::host_in_s host_q;
  logic [7:0] edges_now;
  logic [7:0] edge_set;
  logic [7:0] edge_clr;
  logic data_clr;
  logic wr_acc;
  logic rd_acc;
  logic enabled;
  logic [2:0] mode;
  logic in_fwd_mode;
  logic in_rev_mode;
  logic dev_init;
  logic word_done;
  logic cmd_byte;
  logic wait_done;

  // Access decode helper
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[`ADDR_MSB:0] == off);
  endfunction

  // Status and interrupt-status words both take write-one clears
  function automatic logic clear_hit(input logic [31:0] a);
    clear_hit = hit(a, `OFF_STAT) || hit(a, `OFF_IRQ);
  endfunction

  // Any of the six mapped words; the rest answer with an error
  function automatic logic mapped_hit(input logic [31:0] a);
    mapped_hit = clear_hit(a) || hit(a, `OFF_CTRL) || hit(a, `OFF_MASK)
                 || hit(a, `OFF_LATCH) || hit(a, `OFF_GPO);
  endfunction

  // Setup phase of an access to the external latch
  function automatic logic latch_setup(input logic s, input logic e, input logic [31:0] a);
    latch_setup = s && !e && hit(a, `OFF_LATCH);
  endfunction

  // APB access phase strobes
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign enabled = ctrl[`C_ENABLE];
  assign mode = ctrl[`C_MODE_HI:`C_MODE_LO];
  // Single mode field keeps forward and reverse channels exclusive
  assign in_fwd_mode = enabled && (mode == `MODE_COMPAT || mode == `MODE_ECP_FWD);
  assign in_rev_mode = enabled && (mode == `MODE_BYTE || mode == `MODE_ECP_REV);
  // Device initialisation: reinit with select asserted
  assign dev_init = host_in.init && host_in.active;

  // Edge detect: low nibble rising, high nibble falling
  // Pins arrive already inverted, so high means asserted on the cable
  assign edges_now = {
    ~host_in.init & host_q.init, ~host_in.active & host_q.active,
    ~host_in.autofeed & host_q.autofeed, ~host_in.strobe & host_q.strobe,
    host_in.init & ~host_q.init, host_in.active & ~host_q.active,
    host_in.autofeed & ~host_q.autofeed, host_in.strobe & ~host_q.strobe
  };
  assign edge_set = enabled ? (edges_now & {fall_mask[3:0], rise_mask[3:0]}) : 8'h00;
  // Write-one clears from either flag register
  assign edge_clr = (wr_acc && clear_hit(paddr)) ? pwdata[7:0] : 8'h00;
  assign data_clr = wr_acc && clear_hit(paddr) && pwdata[8];
  // Last byte of a word; the count holds the bytes already completed
  assign word_done = !ctrl[`C_FULLWORD] || (byte_count == `BYTES_PER_WORD);
  // ECP bytes whose command bit matches the expected polarity wait for software
  assign cmd_byte = in_fwd_mode && mode == `MODE_ECP_FWD
                    && host_in.ecp_cmd == ctrl[`C_CMD_POL];
  // Wait ends on acknowledge, or at once for a byte that only fills a word
  assign wait_done = hs_state == HS_WAIT
                     && (transfer_ack || (!word_done && !cmd_byte));

  // Input history for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_q <= '0;
    end else begin
      host_q <= host_in;
    end
  end

  // Control, mask and software status registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `RESET_ZERO;
      rise_mask <= 8'h00;
      fall_mask <= 8'h00;
      data_mask <= 1'b0;
      status_out <= '0;
    end else if (wr_acc) begin
      // Mode changes come only from software writes
      if (hit(paddr, `OFF_CTRL)) begin
        ctrl <= pwdata;
      end
      if (hit(paddr, `OFF_MASK)) begin
        rise_mask <= pwdata[7:0];
        fall_mask <= pwdata[15:8];
        data_mask <= pwdata[16];
      end
      if (hit(paddr, `OFF_GPO)) begin
        status_out <= pwdata[2:0];
      end
    end
  end

  // Sticky edge flags; a new edge beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_stat <= 8'h00;
    end else begin
      edge_stat <= (edge_stat & ~edge_clr) | edge_set;
    end
  end

  // Data-ready flag, raised when a forward byte or word is complete
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_stat <= 1'b0;
    end else begin
      data_stat <= (data_stat & ~data_clr) |
                   (hs_state == HS_WAIT && transfer_ack && word_done && in_fwd_mode);
    end
  end

  // Interrupt lines from masked flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control_irq <= 1'b0;
      data_irq <= 1'b0;
    end else begin
      control_irq <= |edge_stat;
      data_irq <= data_stat && data_mask;
    end
  end

  // Forward handshake sequencer
  // Idle: wait for a strobe edge. Pulse: drive the latch strobe for the
  // mode's width. Wait: hold for the transfer acknowledge or, mid-word, move
  // on at once. Release: acknowledge the host until it drops its strobe.
  // Leaving a forward mode returns the sequencer to idle with no pulse.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_state <= HS_IDLE;
      pulse_cnt <= 3'h0;
    end else if (!in_fwd_mode) begin
      hs_state <= HS_IDLE;
      pulse_cnt <= 3'h0;
    end else begin
      unique case (hs_state)
        HS_IDLE: begin
          if (host_in.strobe && !host_q.strobe) begin
            hs_state <= HS_PULSE;
            pulse_cnt <= (mode == `MODE_ECP_FWD) ? 3'(`ECP_PULSE_CYC)
                                                 : 3'(`COMPAT_PULSE_CYC);
          end
        end
        HS_PULSE: begin
          if (pulse_cnt == 3'h1) begin
            hs_state <= HS_WAIT;
          end
          pulse_cnt <= pulse_cnt - 3'h1;
        end
        HS_WAIT: begin
          // Release once the byte or word is taken
          if (wait_done) begin
            hs_state <= HS_RELEASE;
          end
        end
        HS_RELEASE: begin
          if (!host_in.strobe) begin
            hs_state <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // Completed byte handshakes toward a full word; wraps after the fourth
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_count <= 2'h0;
    end else if (!ctrl[`C_FULLWORD]) begin
      byte_count <= 2'h0;
    end else if (wait_done && !cmd_byte) begin
      byte_count <= byte_count + 2'h1;
    end
  end

  // Transfer request, only on completed byte or word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transfer_request <= 1'b0;
    end else begin
      transfer_request <= in_fwd_mode && hs_state == HS_WAIT && word_done
                          && !cmd_byte && !transfer_ack;
    end
  end

  // Handshake outputs toward the host
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      peripheral_ack_out <= 1'b0;
      peripheral_busy_out <= 1'b0;
    end else if (!enabled) begin
      peripheral_ack_out <= 1'b0;
      peripheral_busy_out <= 1'b0;
    end else begin
      peripheral_ack_out <= (hs_state == HS_RELEASE);
      peripheral_busy_out <= (hs_state != HS_IDLE) ||
                             (mode == `MODE_COMPAT && ctrl[`C_ABC]);
    end
  end

  // Shared pins: port logic or general-purpose outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      forward_latch_pulse <= 1'b0;
      reverse_drive_enable <= 1'b0;
    end else if (!enabled) begin
      forward_latch_pulse <= gpio_pin6_out;
      reverse_drive_enable <= gpio_pin8_out;
    end else begin
      forward_latch_pulse <= (hs_state == HS_PULSE);
      reverse_drive_enable <= in_rev_mode && ctrl[`C_REVERSE_DRIVE_ENABLE] && !dev_init;
    end
  end

  // Latch read and write enables during the access phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_read_enable <= 1'b0;
      latch_write_enable <= 1'b0;
    end else begin
      latch_read_enable <= enabled && !pwrite
                           && latch_setup(psel, penable, paddr);
      latch_write_enable <= enabled && pwrite
                            && latch_setup(psel, penable, paddr);
    end
  end

  // APB read data and answer, always zero wait
  // pready rises in the cycle after setup, so every access is one access cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= `RESET_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped_hit(paddr);
      if (psel && !penable && !pwrite) begin
        if (hit(paddr, `OFF_CTRL)) begin
          prdata <= ctrl;
        end else if (hit(paddr, `OFF_STAT)) begin
          // Edges, data flag, pins, state, then the byte count at the top
          prdata <= {12'h000, byte_count, 2'b00, hs_state, host_in, data_stat, edges_now};
        end else if (hit(paddr, `OFF_MASK)) begin
          prdata <= {15'h0000, data_mask, fall_mask, rise_mask};
        end else if (hit(paddr, `OFF_IRQ)) begin
          prdata <= {23'h000000, data_stat & data_mask, edge_stat};
        end else if (hit(paddr, `OFF_GPO)) begin
          prdata <= {29'h00000000, status_out};
        end else begin
          prdata <= `RESET_ZERO;
        end
      end
    end
  end

endmodule

/* File: tb/parallel_peripheral_port_sva.sv */
// Checker bound to the parallel peripheral port top module.
// Assumes control writes land at the APB access edge.
`timescale 1ns/1ps
`include "ppp_defines.svh"
module parallel_peripheral_port_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic transfer_ack,
  input wire logic peripheral_ack_out,
  input wire logic peripheral_busy_out,
  input wire logic latch_read_enable,
  input wire logic latch_write_enable,
  input wire logic forward_latch_pulse,
  input wire ppp_pkg::host_in_s host_in,
  input wire ppp_pkg::soft_status_s status_out,
  input wire logic transfer_request
);
  logic [7:0] ctrl;
  logic acc;
  logic dec;
  logic en;
  logic [2:0] mode;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Access edge, latch decode and control fields
  assign acc = psel && penable && pready;
  assign dec = acc && paddr[7:0] == `OFF_LATCH;
  assign en = ctrl[`C_ENABLE];
  assign mode = ctrl[`C_MODE_HI:`C_MODE_LO];
  // Shadow of the control word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= 8'h00;
    end else if (acc && pwrite && paddr[7:0] == `OFF_CTRL) begin
      ctrl <= pwdata[7:0];
    end
  end
  latch_rd_a: assert property (dec && !pwrite && en |-> latch_read_enable)
    else $error("latch read enable missing");
  latch_wr_a: assert property (dec && pwrite && en |-> latch_write_enable)
    else $error("latch write enable missing");
  latch_idle_a: assert property (
    !(dec && en) |-> !latch_read_enable && !latch_write_enable) else $error("stray latch enable");
  quiet_off_a: assert property (
    !en && !$past(en) |-> !peripheral_ack_out && !peripheral_busy_out) else $error("handshake off");
  strobe_pulse_a: assert property (
    $rose(host_in.strobe) && en && (mode == `MODE_COMPAT || mode == `MODE_ECP_FWD)
    |-> ##2 forward_latch_pulse) else $error("no latch pulse after strobe");
  compat_width_a: assert property (
    $rose(forward_latch_pulse) && en && mode == `MODE_COMPAT
    |-> forward_latch_pulse [*5] ##1 !forward_latch_pulse) else $error("compat pulse width");
  ecp_width_a: assert property (
    $rose(forward_latch_pulse) && en && mode == `MODE_ECP_FWD
    |-> forward_latch_pulse [*2] ##1 !forward_latch_pulse) else $error("ecp pulse width");
  busy_pulse_a: assert property (forward_latch_pulse && en |-> peripheral_busy_out)
    else $error("busy low during latch pulse");
  req_hold_a: assert property (transfer_request && !transfer_ack |=> transfer_request)
    else $error("request dropped before ack");
  soft_status_a: assert property (
    !(acc && pwrite && paddr[7:0] == `OFF_GPO) |=> $stable(status_out)) else $error("status moved");
  cover property ($rose(forward_latch_pulse) && en);
  cover property (dec && pwrite);
  cover property (transfer_request && transfer_ack);
endmodule
bind parallel_peripheral_port parallel_peripheral_port_sva u_parallel_peripheral_port_sva (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .transfer_ack(transfer_ack),
  .peripheral_ack_out(peripheral_ack_out), .peripheral_busy_out(peripheral_busy_out),
  .latch_read_enable(latch_read_enable), .latch_write_enable(latch_write_enable),
  .forward_latch_pulse(forward_latch_pulse), .host_in(host_in), .status_out(status_out),
  .transfer_request(transfer_request));

/* File: tb/host_model.sv */
// Host end of the cable, as seen at the device pins after inversion.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic peripheral_ack_out,
  output ppp_pkg::host_in_s host_in
);
  // Idle lines are low at the device side of the inverters
  initial begin
    host_in = '0;
  end
  // Interlocked strobe: hold until acknowledged, then wait for release
  task automatic send_byte(input logic cmd, output bit ok);
    int n;
    host_in.ecp_cmd <= cmd;
    host_in.strobe <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (peripheral_ack_out !== 1'b1 && n < 200);
    ok = (peripheral_ack_out === 1'b1);
    host_in.strobe <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (peripheral_ack_out === 1'b1 && n < 400);
  endtask
  // Select and autofeed move together to request or end a mode
  task automatic negotiate(input logic v);
    host_in.active <= v;
    host_in.autofeed <= v;
    @(posedge clk);
  endtask
endmodule

/* File: tb/parallel_peripheral_port_tb_top.sv */
// Testbench for the parallel peripheral port: APB tasks and host traffic.
// Assumes the host model drives the host pins and each request is acked.
`timescale 1ns/1ps
`include "ppp_defines.svh"
module parallel_peripheral_port_tb_top;
  logic clk = 0;
  logic arst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, peripheral_ack_out, peripheral_busy_out, latch_read_enable;
  logic latch_write_enable, forward_latch_pulse, reverse_drive_enable, transfer_request;
  logic control_irq, data_irq, e;
  logic gpio_pin6_out = 0;
  logic gpio_pin8_out = 0;
  logic transfer_ack = 0;
  logic [31:0] q;
  logic [31:0] fwd [2] = '{32'h3, 32'h29};
  ppp_pkg::host_in_s host_in;
  ppp_pkg::soft_status_s status_out;
  int bad_count = 0;
  int n_compared = 0;
  int reqs = 0;
  int rds = 0;
  int wrs = 0;
  bit ok;
  always #5 clk = ~clk;
  parallel_peripheral_port u_parallel_peripheral_port (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_in(host_in),
    .gpio_pin6_out(gpio_pin6_out), .gpio_pin8_out(gpio_pin8_out), .transfer_ack(transfer_ack),
    .peripheral_ack_out(peripheral_ack_out), .peripheral_busy_out(peripheral_busy_out),
    .latch_read_enable(latch_read_enable), .latch_write_enable(latch_write_enable),
    .forward_latch_pulse(forward_latch_pulse), .reverse_drive_enable(reverse_drive_enable),
    .status_out(status_out), .transfer_request(transfer_request), .control_irq(control_irq),
    .data_irq(data_irq));
  host_model u_host_model (.clk(clk), .peripheral_ack_out(peripheral_ack_out),
    .host_in(host_in));
  // Acknowledge each request once and count latch strobes
  always @(posedge clk) begin
    transfer_ack <= transfer_request && !transfer_ack;
    if (transfer_request && !transfer_ack) reqs++;
    if (latch_read_enable) rds++;
    if (latch_write_enable) wrs++;
  end
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
    n_compared++;
    if (y !== x) begin
      $display("[FAIL] %s expected %h seen %h", s, x, y);
      bad_count++;
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      summarize();
    end
    @(posedge clk);
  endtask
  task automatic waitv(ref logic s, input logic v, input string nm);
    int n;
    for (n = 0; n < 20 && s !== v; n++) @(posedge clk);
    chk(nm, {31'h0, v}, {31'h0, s});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(0, `OFF_CTRL, 0);
    chk("ctrl reset", 0, q);
    apb(0, 8'hc0, 0);
    chk("unmapped error", 1, {31'h0, e});
    apb(0, `OFF_LATCH, 0);
    chk("latch reads off", 0, rds);
    gpio_pin6_out <= 1'b1;
    gpio_pin8_out <= 1'b1;
    waitv(forward_latch_pulse, 1'b1, "pin6 owner");
    waitv(reverse_drive_enable, 1'b1, "pin8 owner");
    gpio_pin6_out <= 1'b0;
    gpio_pin8_out <= 1'b0;
    apb(1, `OFF_CTRL, 32'h3);
    apb(0, `OFF_CTRL, 0);
    chk("ctrl mode", 32'h3, q);
    apb(0, `OFF_LATCH, 0);
    apb(1, `OFF_LATCH, 32'h5a);
    chk("latch reads", 1, rds);
    chk("latch writes", 1, wrs);
    // Back-to-back bytes in compatibility and ECP forward
    foreach (fwd[i]) begin
      apb(1, `OFF_CTRL, fwd[i]);
      reqs = 0;
      repeat (2) begin
        u_host_model.send_byte(1'b0, ok);
        chk("byte handshake", 1, {31'h0, ok});
      end
      chk("byte requests", 2, reqs);
    end
    apb(1, `OFF_MASK, 32'h10000);
    waitv(data_irq, 1'b1, "data irq");
    apb(1, `OFF_STAT, 32'h100);
    waitv(data_irq, 1'b0, "data irq cleared");
    apb(1, `OFF_CTRL, 32'h13);
    reqs = 0;
    for (int i = 1; i <= 4; i++) begin
      u_host_model.send_byte(1'b0, ok);
      chk("word handshake", 1, {31'h0, ok});
      chk("word requests", i / 4, reqs);
    end
    apb(1, `OFF_CTRL, 32'h87);
    waitv(reverse_drive_enable, 1'b1, "reverse drive");
    apb(1, `OFF_MASK, 32'h2);
    u_host_model.negotiate(1'b1);
    waitv(control_irq, 1'b1, "irq raised");
    apb(1, `OFF_IRQ, 32'h2);
    waitv(control_irq, 1'b0, "irq cleared");
    apb(0, `OFF_CTRL, 0);
    chk("mode kept", 32'h87, q);
    apb(1, `OFF_GPO, 32'h5);
    chk("status lines", 32'h5, {29'h0, status_out});
    apb(1, `OFF_CTRL, 0);
    rds = 0;
    apb(0, `OFF_LATCH, 0);
    chk("ack busy off", 0, {30'h0, peripheral_ack_out, peripheral_busy_out});
    chk("latch reads off", 0, rds);
    summarize();
  end
endmodule
